/* core/cmd_mailbox_pkg.sv */
// constants and types shared by the command mailbox
// assumes a 100 MHz single clock domain and an AXI4-Lite register master
package cmd_mailbox_pkg;

    typedef enum logic [1:0] {
        PH_RECV,
        PH_CHECK,
        PH_CHAN,
        PH_REPLY
    } phase_t;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STATE      = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h0c;
    localparam logic [7:0]  OFS_LAST_STAT  = 8'h10;
    localparam logic [7:0]  OFS_CMD_COUNT  = 8'h14;

    // field positions and reset values
    localparam int          HEALTHY_BIT    = 16;
    localparam logic [0:0]  CTRL_RESET     = 1'h0;
    localparam logic [2:0]  IRQ_RESET      = 3'h0;
    localparam int          IRQ_REPLY      = 0;
    localparam int          IRQ_ERROR      = 1;
    localparam int          IRQ_CHAN_FAIL  = 2;

    // command block layout, counts in 16-bit words; MAX_BYTES in bytes, NUM_CHANNELS in channels
    localparam logic [7:0]  HDR_WORDS      = 8'h06;
    localparam logic [7:0]  KEPT_WORDS     = 8'h09;
    localparam logic [15:0] MAX_DATA_WORDS = 16'h007a;
    localparam logic [15:0] MAX_BYTES      = 16'h0800;
    localparam logic [15:0] NUM_CHANNELS   = 16'h0020;

    // command codes
    localparam logic [15:0] CMD_ABORT      = 16'h07d1;
    localparam logic [15:0] CMD_RETRIEVE   = 16'h07d2;
    localparam logic [15:0] CMD_EST_READ   = 16'h07d3;
    localparam logic [15:0] CMD_EST_WRITE  = 16'h07d4;

    // status words: low byte major, high byte minor
    localparam logic [15:0] STAT_OK        = 16'h0001;
    localparam logic [7:0]  MAJ_SYNTAX     = 8'h0c;
    localparam logic [7:0]  MAJ_CHANNEL    = 8'h0d;
    localparam logic [7:0]  MIN_LENGTH     = 8'h01;
    localparam logic [7:0]  MIN_WAIT       = 8'h02;
    localparam logic [7:0]  MIN_RESERVED   = 8'h03;
    localparam logic [7:0]  MIN_COUNT      = 8'h04;
    localparam logic [7:0]  MIN_CHAN_NUM   = 8'h05;
    localparam logic [7:0]  MIN_BYTES      = 8'h06;
    localparam logic [7:0]  MIN_UNKNOWN    = 8'h07;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : cmd_mailbox_pkg

/* core/cmd_mailbox.sv */
// command mailbox: takes command blocks from the cpu, answers each
// with one non-zero status word; registers over AXI4-Lite.
// assumes the cpu and the channel engine run on clk_i.
`timescale 1ns/10ps
`default_nettype none
module cmd_mailbox
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    // AXI4-Lite slave
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [7:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic [1:0]                      s_axi_bresp,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [7:0]                 s_axi_araddr,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    // command block words from the cpu
    input  wire logic                       cmd_valid_i,
    output logic                            cmd_ready_o,
    input  wire logic [15:0]                cmd_word_i,
    input  wire logic                       cmd_last_i,
    // status word back to the cpu
    output logic                            stat_valid_o,
    input  wire logic                       stat_ready_i,
    output logic [15:0]                     stat_mem_type_o,
    output logic [15:0]                     stat_offset_o,
    output logic [15:0]                     stat_word_o,
    // channel engine
    output logic                            chan_start_o,
    output logic                            chan_abort_o,
    output logic                            chan_write_o,
    output logic [4:0]                      chan_num_o,
    output logic [11:0]                     chan_bytes_o,
    input  wire logic                       chan_done_i,
    input  wire logic                       chan_fail_i,
    input  wire logic [7:0]                 chan_code_i,
    output logic                            controller_healthy_flag_o,
    output logic                            irq_o
);
    import cmd_mailbox_pkg::*;

    typedef struct packed {
        phase_t            phase;
        logic [5:0][15:0]  hdr;
        logic [2:0][15:0]  dat;
        logic [7:0]        cnt;
        logic [15:0]       stat;
        logic              chan_start;
        logic              chan_abort;
        logic              aw_full;
        logic [7:0]        aw_addr;
        logic              w_full;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [0:0]        ctrl;
        logic [2:0]        irq_stat;
        logic [2:0]        irq_mask;
        logic [15:0]       last_stat;
        logic [31:0]       cmd_count;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_STATE) ||
                 (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK) ||
                 (a == OFS_LAST_STAT) || (a == OFS_CMD_COUNT);
    endfunction : mapped

    function automatic logic [15:0] syntax_err(input state_t s);
        logic [15:0] len;
        logic [15:0] code;
        len  = s.hdr[0];
        code = s.dat[0];
        syntax_err = 16'h0000;
        if (len == 16'h0000 || len > MAX_DATA_WORDS)
            syntax_err = {MIN_LENGTH, MAJ_SYNTAX};
        else if (s.hdr[1] != 16'h0000)
            syntax_err = {MIN_WAIT, MAJ_SYNTAX};
        else if ((s.hdr[4] | s.hdr[5]) != 16'h0000)
            syntax_err = {MIN_RESERVED, MAJ_SYNTAX};
        else if ({8'h00, s.cnt} != len + {8'h00, HDR_WORDS})
            syntax_err = {MIN_COUNT, MAJ_SYNTAX};
        else if (code != CMD_ABORT && code != CMD_RETRIEVE &&
                 code != CMD_EST_READ && code != CMD_EST_WRITE)
            syntax_err = {MIN_UNKNOWN, MAJ_SYNTAX};
        else if (len < 16'h0002 || s.dat[1] >= NUM_CHANNELS)
            syntax_err = {MIN_CHAN_NUM, MAJ_SYNTAX};
        else if ((code == CMD_EST_READ || code == CMD_EST_WRITE) &&
                 (len < 16'h0003 || s.dat[2] == 16'h0000 ||
                  s.dat[2] > MAX_BYTES))
            syntax_err = {MIN_BYTES, MAJ_SYNTAX};
    endfunction : syntax_err

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                merge[8*i +: 8] = d[8*i +: 8];
        end
    endfunction : merge

    logic        wr_go;
    logic        rd_go;
    logic        reply_done;
    logic [2:0]  ev;
    logic [15:0] err;
    logic [31:0] wval;

    always_comb
    begin
        s_nxt      = s_r;
        ev         = 3'h0;
        err        = syntax_err(s_r);
        reply_done = (s_r.phase == PH_REPLY) && stat_ready_i;
        s_nxt.chan_start = 1'b0;
        s_nxt.chan_abort = 1'b0;

        unique case (s_r.phase)
            PH_RECV:
            begin
                // only here is a new block taken
                if (cmd_valid_i && cmd_ready_o)
                begin
                    if (s_r.cnt < HDR_WORDS)
                        s_nxt.hdr[s_r.cnt[2:0]] = cmd_word_i;
                    else if (s_r.cnt < KEPT_WORDS)
                        s_nxt.dat[2'(s_r.cnt - HDR_WORDS)] = cmd_word_i;
                    // saturate so an overlong block still fails the check
                    if (s_r.cnt != 8'hff)
                        s_nxt.cnt = s_r.cnt + 8'h01;
                    if (cmd_last_i)
                        s_nxt.phase = PH_CHECK;
                end
            end
            PH_CHECK:
            begin
                if (err != 16'h0000)
                begin
                    s_nxt.stat  = err;
                    s_nxt.phase = PH_REPLY;
                end
                else if (s_r.dat[0] == CMD_ABORT ||
                         s_r.dat[0] == CMD_RETRIEVE)
                begin
                    s_nxt.stat       = STAT_OK;
                    s_nxt.chan_abort = (s_r.dat[0] == CMD_ABORT);
                    s_nxt.phase      = PH_REPLY;
                end
                else
                begin
                    s_nxt.chan_start = 1'b1;
                    s_nxt.phase      = PH_CHAN;
                end
            end
            PH_CHAN:
            begin
                // hold the reply until the first transfer ends
                if (chan_done_i)
                begin
                    s_nxt.stat  = chan_fail_i ?
                                  {chan_code_i, MAJ_CHANNEL} : STAT_OK;
                    s_nxt.phase = PH_REPLY;
                    ev[IRQ_CHAN_FAIL] = chan_fail_i;
                end
            end
            PH_REPLY:
            begin
                // one write per block, then back to listening
                if (reply_done)
                begin
                    s_nxt.last_stat = s_r.stat;
                    s_nxt.cmd_count = s_r.cmd_count + 32'h1;
                    s_nxt.cnt       = 8'h00;
                    s_nxt.phase     = PH_RECV;
                    ev[IRQ_REPLY]   = 1'b1;
                    ev[IRQ_ERROR]   = (s_r.stat != STAT_OK);
                end
            end
        endcase

        // write channel: address and data latched in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_nxt.aw_full = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_nxt.w_full = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        // a pending response holds off the next write until taken
        wr_go = s_r.aw_full && s_r.w_full && !s_r.bvalid;
        wval  = 32'h0;
        if (wr_go)
        begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = mapped(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_r.aw_addr)
                OFS_CTRL:
                begin
                    wval = merge({31'h0, s_r.ctrl}, s_r.w_data, s_r.w_strb);
                    s_nxt.ctrl = wval[0:0];
                end
                OFS_IRQ_MASK:
                begin
                    wval = merge({29'h0, s_r.irq_mask},
                                 s_r.w_data, s_r.w_strb);
                    s_nxt.irq_mask = wval[2:0];
                end
                OFS_IRQ_STAT:
                begin
                    if (s_r.w_strb[0])
                        s_nxt.irq_stat = s_r.irq_stat & ~s_r.w_data[2:0];
                end
                default:
                begin
                end
            endcase
        end
        else if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;

        // set after the clear so a new event is never lost
        s_nxt.irq_stat = s_nxt.irq_stat | ev;

        rd_go = s_axi_arvalid && s_axi_arready;
        if (rd_go)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFS_CTRL:      s_nxt.rdata = {31'h0, s_r.ctrl};
                OFS_STATE:
                begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rdata[HEALTHY_BIT] = s_r.ctrl[0];
                    s_nxt.rdata[1:0] = s_r.phase;
                    s_nxt.rdata[15:8] = s_r.cnt;
                end
                OFS_IRQ_STAT:  s_nxt.rdata = {29'h0, s_r.irq_stat};
                OFS_IRQ_MASK:  s_nxt.rdata = {29'h0, s_r.irq_mask};
                OFS_LAST_STAT: s_nxt.rdata = {16'h0, s_r.last_stat};
                OFS_CMD_COUNT: s_nxt.rdata = s_r.cmd_count;
                default:       s_nxt.rdata = 32'h0;
            endcase
        end
        else if (s_r.rvalid && s_axi_rready)
            s_nxt.rvalid = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            s_r           <= '0;
            s_r.phase     <= PH_RECV;
            s_r.ctrl      <= CTRL_RESET;
            s_r.irq_stat  <= IRQ_RESET;
            s_r.irq_mask  <= IRQ_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // the cpu is expected to hold off while the flag is low; we also
    // refuse words then so a half-enabled controller latches nothing
    assign controller_healthy_flag_o = s_r.ctrl[0];
    assign cmd_ready_o    = (s_r.phase == PH_RECV) && s_r.ctrl[0];

    assign stat_valid_o    = (s_r.phase == PH_REPLY);
    // every path into stat loads a code with a non-zero byte
    assign stat_word_o     = s_r.stat;
    assign stat_mem_type_o = s_r.hdr[2];
    // passed on unchanged: the cpu resolves the zero-based index
    assign stat_offset_o   = s_r.hdr[3];

    assign chan_start_o  = s_r.chan_start;
    assign chan_abort_o  = s_r.chan_abort;
    assign chan_write_o  = (s_r.dat[0] == CMD_EST_WRITE);
    assign chan_num_o    = s_r.dat[1][4:0];
    assign chan_bytes_o  = s_r.dat[2][11:0];

    assign irq_o = |(s_r.irq_stat & s_r.irq_mask);

    // one write outstanding: hold address or data until paired
    assign s_axi_awready = !s_r.aw_full;
    assign s_axi_wready  = !s_r.w_full;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;

endmodule : cmd_mailbox
`default_nettype wire

/* dv/cmd_mailbox_checker.sv */
// assertions on the command mailbox handshake
// assumes binding into cmd_mailbox; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module cmd_mailbox_checker
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_ready_o,
    input  wire logic        cmd_last_i,
    input  wire logic        stat_valid_o,
    input  wire logic        stat_ready_i,
    input  wire logic [15:0] stat_word_o,
    input  wire logic        chan_start_o,
    input  wire logic        chan_done_i,
    input  wire logic        chan_fail_i,
    input  wire logic [7:0]  chan_code_i
);
    import cmd_mailbox_pkg::*;
    logic wait_r;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // engine answer is only meaningful between start and done
    always_ff @(posedge clk_i)
        if (!rst_b_i)
            wait_r <= 1'b0;
        else if (chan_start_o)
            wait_r <= 1'b1;
        else if (chan_done_i)
            wait_r <= 1'b0;

    property p_nonzero;
        stat_valid_o |-> stat_word_o != 16'h0000;
    endproperty
    a_nonzero: assert property (p_nonzero) else $error("zero status");
    property p_ok;
        wait_r && chan_done_i && !chan_fail_i |-> ##[1:2]
            (stat_valid_o && stat_word_o == STAT_OK);
    endproperty
    a_ok: assert property (p_ok) else $error("bad success");
    property p_fail;
        wait_r && chan_done_i && chan_fail_i |=>
            stat_valid_o && stat_word_o == {$past(chan_code_i), MAJ_CHANNEL};
    endproperty
    a_fail: assert property (p_fail) else $error("bad fail code");
    property p_now;
        cmd_valid_i && cmd_ready_o && cmd_last_i |-> ##2
            (stat_valid_o || chan_start_o);
    endproperty
    a_now: assert property (p_now) else $error("late reply");
    property p_hold;
        wait_r && !chan_done_i |-> !stat_valid_o;
    endproperty
    a_hold: assert property (p_hold) else $error("early reply");
    property p_stand;
        stat_valid_o && !stat_ready_i |=> stat_valid_o && $stable(stat_word_o);
    endproperty
    a_stand: assert property (p_stand) else $error("status moved");
    property p_once;
        stat_valid_o && stat_ready_i |=> !stat_valid_o [*3];
    endproperty
    a_once: assert property (p_once) else $error("second status");
    property p_refuse;
        stat_valid_o |-> !cmd_ready_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("block taken");
endmodule : cmd_mailbox_checker

bind cmd_mailbox cmd_mailbox_checker u_chk (.*);
`default_nettype wire

/* dv/cpu_model.sv */
// requester model: sends command blocks, collects status words,
// and answers for the channel engine behind the mailbox
// assumes the bench fills blk and n before calling go
`timescale 1ns/10ps
`default_nettype none
module cpu_model
(
    input  wire logic        clk_i,
    input  wire logic        ready_i,
    input  wire logic        healthy_i,
    input  wire logic        stat_valid_i,
    input  wire logic [15:0] stat_word_i,
    input  wire logic [15:0] stat_offset_i,
    input  wire logic        chan_start_i,
    output logic             cmd_valid_o,
    output logic [15:0]      cmd_word_o,
    output logic             cmd_last_o,
    output logic             stat_ready_o,
    output logic             done_o,
    output logic             fail_o,
    output logic [7:0]       code_o
);
    logic [15:0] blk [0:131];
    logic [15:0] last_off;
    int          n = 6;
    int          lat = 1;
    logic        fail_sel = 1'b0;
    logic [7:0]  code_sel = 8'h00;
    // slot 4 of the main rack, channel command mailbox
    logic [15:0] rack_slot_selector = 16'h0004;
    int          mailbox_task = 0;
    logic        delivery_fault_output = 1'b0;

    initial
    begin
        {cmd_valid_o, cmd_last_o, stat_ready_o, done_o, fail_o} = 5'h00;
        cmd_word_o = 16'h0000;
        code_o = 8'h00;
    end

    task go(output logic [15:0] command_status_word);
        command_status_word = 16'h0000;
        delivery_fault_output = 1'b0;
        @(negedge clk_i);
        // undeliverable block: raise the fault, leave status at zero
        if (!healthy_i || rack_slot_selector[15:8] != 8'h00 ||
            mailbox_task != 0)
        begin
            delivery_fault_output = 1'b1;
            return;
        end
        @(posedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            cmd_valid_o <= 1'b1;
            cmd_word_o  <= blk[i];
            cmd_last_o  <= (i == n - 1);
            @(negedge clk_i);
            while (!ready_i) @(negedge clk_i);
            @(posedge clk_i);
        end
        // word lines do not keep the last value once released
        cmd_valid_o <= 1'b0;
        cmd_word_o  <= ~blk[n - 1];
        cmd_last_o  <= 1'b0;
        @(negedge clk_i);
        while (stat_valid_i !== 1'b1) @(negedge clk_i);
        command_status_word = stat_word_i;
        last_off = stat_offset_i;
        @(posedge clk_i);
        stat_ready_o <= 1'b1;
        @(posedge clk_i);
        stat_ready_o <= 1'b0;
    endtask : go

    // engine: lat sets a prompt or slow answer
    always @(negedge clk_i)
        if (chan_start_i)
        begin
            repeat (lat) @(posedge clk_i);
            done_o <= 1'b1;
            fail_o <= fail_sel;
            code_o <= code_sel;
            @(posedge clk_i);
            done_o <= 1'b0;
            fail_o <= ~fail_sel;
            code_o <= ~code_sel;
        end
endmodule : cpu_model
`default_nettype wire

/* dv/cmd_mailbox_tb.sv */
// self-checking bench for the command mailbox
// assumes cpu_model as requester and engine; AXI4-Lite tasks here
`timescale 1ns/10ps
`default_nettype none
module cmd_mailbox_tb;
    import cmd_mailbox_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, irq_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic cmd_valid_i, cmd_ready_o, cmd_last_i, stat_valid_o, stat_ready_i;
    logic [15:0] cmd_word_i, stat_mem_type_o, stat_offset_o, stat_word_o, st;
    logic chan_start_o, chan_abort_o, chan_write_o, chan_done_i, chan_fail_i;
    logic [4:0] chan_num_o;
    logic [11:0] chan_bytes_o;
    logic [7:0] chan_code_i;
    logic controller_healthy_flag_o;
    int error_cnt = 0, check_count = 0;
    int abort_cnt = 0;

    always #5 clk_i = ~clk_i;

    // pulse counted mid-cycle, away from the edge that launches it
    always @(negedge clk_i)
        if (chan_abort_o === 1'b1)
            abort_cnt++;

    cmd_mailbox u_dut (.*);
    cpu_model u_cpu (.clk_i(clk_i), .ready_i(cmd_ready_o),
        .healthy_i(controller_healthy_flag_o), .stat_valid_i(stat_valid_o),
        .stat_word_i(stat_word_o), .stat_offset_i(stat_offset_o),
        .chan_start_i(chan_start_o), .cmd_valid_o(cmd_valid_i),
        .cmd_word_o(cmd_word_i), .cmd_last_o(cmd_last_i),
        .stat_ready_o(stat_ready_i), .done_o(chan_done_i),
        .fail_o(chan_fail_i), .code_o(chan_code_i));

    task summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] v);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk_i);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata  <= v;
        s_axi_wstrb  <= 4'hf;
        while (pa || pw)
        begin
            @(negedge clk_i);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge clk_i);
            s_axi_awvalid <= pa;
            s_axi_wvalid  <= pw;
        end
        @(negedge clk_i);
        while (!s_axi_bvalid) @(negedge clk_i);
        r = s_axi_bresp;
        @(posedge clk_i);
        s_axi_bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge clk_i);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        @(negedge clk_i);
        while (!s_axi_arready) @(negedge clk_i);
        @(posedge clk_i);
        s_axi_arvalid <= 1'b0;
        @(negedge clk_i);
        while (!s_axi_rvalid) @(negedge clk_i);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk_i);
        s_axi_rready <= 1'b0;
    endtask : rd

    task cmd(input int len, wt, rsv, input logic [15:0] code,
             input int ch, by, n, input logic [15:0] exp);
        for (int i = 0; i < 132; i++) u_cpu.blk[i] = 16'h0000;
        u_cpu.blk[0] = 16'(len);
        u_cpu.blk[1] = 16'(wt);
        u_cpu.blk[2] = 16'h0008;
        u_cpu.blk[3] = 16'h0063;
        u_cpu.blk[4] = 16'(rsv);
        u_cpu.blk[6] = code;
        u_cpu.blk[7] = 16'(ch);
        u_cpu.blk[8] = 16'(by);
        u_cpu.n = n;
        u_cpu.go(st);
        chk({16'h0, st}, {16'h0, exp});
    endtask : cmd

    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        summarize();
    end

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(OFS_CTRL);
        chk(d, 32'h0);
        rd(OFS_IRQ_MASK);
        chk(d, 32'h0);
        rd(8'h18);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h18, 32'hffff_ffff);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk({31'h0, cmd_ready_o}, 32'h0);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_IRQ_MASK, 32'h7);
        rd(OFS_STATE);
        chk({31'h0, d[HEALTHY_BIT]}, 32'h1);
        cmd(2, 0, 0, CMD_ABORT, 3, 0, 8, STAT_OK);
        chk({16'h0, u_cpu.last_off}, 32'h63);
        chk({16'h0, stat_mem_type_o}, 32'h8);
        chk({31'h0, u_cpu.delivery_fault_output}, 32'h0);
        cmd(2, 0, 0, CMD_RETRIEVE, 3, 0, 8, STAT_OK);
        cmd(122, 0, 0, CMD_ABORT, 3, 0, 128, STAT_OK);
        cmd(123, 0, 0, CMD_ABORT, 3, 0, 129, 16'h010c);
        cmd(0, 0, 0, CMD_ABORT, 3, 0, 6, 16'h010c);
        cmd(2, 1, 0, CMD_ABORT, 3, 0, 8, 16'h020c);
        cmd(2, 0, 1, CMD_ABORT, 3, 0, 8, 16'h030c);
        cmd(3, 0, 0, CMD_ABORT, 3, 0, 8, 16'h040c);
        cmd(2, 0, 0, 16'h07d0, 3, 0, 8, 16'h070c);
        cmd(3, 0, 0, CMD_EST_READ, 32, 1, 9, 16'h050c);
        cmd(3, 0, 0, CMD_EST_READ, 31, 0, 9, 16'h060c);
        cmd(3, 0, 0, CMD_EST_WRITE, 3, 2049, 9, 16'h060c);
        cmd(3, 0, 0, CMD_EST_READ, 31, 2048, 9, STAT_OK);
        chk({31'h0, chan_write_o}, 32'h0);
        u_cpu.lat = 40;
        u_cpu.fail_sel = 1'b1;
        u_cpu.code_sel = 8'h33;
        cmd(3, 0, 0, CMD_EST_WRITE, 5, 2048, 9, 16'h330d);
        chk({31'h0, chan_write_o}, 32'h1);
        chk({27'h0, chan_num_o}, 32'h5);
        chk({20'h0, chan_bytes_o}, 32'h800);
        rd(OFS_IRQ_STAT);
        chk(d, 32'h7);
        chk({31'h0, irq_o}, 32'h1);
        wr(OFS_IRQ_STAT, 32'h7);
        rd(OFS_IRQ_STAT);
        chk({d[30:0], irq_o}, 32'h0);
        rd(OFS_LAST_STAT);
        chk(d, 32'h330d);
        rd(OFS_CMD_COUNT);
        chk(d, 32'he);
        wr(OFS_IRQ_MASK, 32'h0);
        cmd(2, 0, 0, CMD_ABORT, 0, 0, 8, STAT_OK);
        rd(OFS_IRQ_STAT);
        chk({d[30:0], irq_o}, 32'h2);
        wr(OFS_CTRL, 32'h0);
        chk({31'h0, cmd_ready_o}, 32'h0);
        u_cpu.go(st);
        chk({16'h0, st}, 32'h0);
        chk({31'h0, u_cpu.delivery_fault_output}, 32'h1);
        chk(32'(abort_cnt), 32'h3);
        summarize();
    end
endmodule : cmd_mailbox_tb
`default_nettype wire
